//--- logic/acr_defs.svh
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// result word length in bits
`define ACR_RESULT_BITS 18
// conversion time in ns and its count of mclk cycles (8 ns period), longest time rounds down
`define ACR_CONV_TIME_NS 500
`define ACR_MCLK_PERIOD_NS 8
`define ACR_CONV_CYCLES (`ACR_CONV_TIME_NS / `ACR_MCLK_PERIOD_NS)
// reset value of the stand-in result
`define ACR_RESULT_RESET 18'h00000

`endif

//--- logic/acr_pkg.sv
package acr_pkg;
  // interface mode latched at the trigger edge
  typedef enum logic [1:0] {
    ACR_MODE_SEL,
    ACR_MODE_SEL_BUSY,
    ACR_MODE_CHAIN,
    ACR_MODE_CHAIN_BUSY
  } acr_mode_t;

  // conversion sequencer phases
  typedef enum logic [1:0] {
    ACR_PH_ACQ,
    ACR_PH_CONV,
    ACR_PH_DONE
  } acr_phase_t;
endpackage : acr_pkg

//--- logic/acr_readout.sv
// Functional notes
// - select high at trigger rise: convert, output tristate
// - select and trigger both low: drive low
// - select busy mode: drive output at completion
// - after completion, acquire and power down converter
// - msb first, advance on shift-clock fall
// - busy select: tristate at 19th fall or select
// - shift clock low at trigger: chain, no busy
// - chain without busy: msb out at completion
// - chain: shift select input in on fall
// - shift clock high at trigger: chain, busy
// - chain busy: drive high once conversion done
// - mode latched at each trigger rising edge
// - 18-bit result; plain select tristate at 18th
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.svh"

module acr_readout
  import acr_pkg::*;
#(
  parameter int CONV_CYCLES = `ACR_CONV_CYCLES
)(
  input  wire logic                         mclk,               // core clock, 125 MHz
  input  wire logic                         srst,               // synchronous reset, active high
  input  wire logic                         shift_clk,          // host shift clock, link domain
  input  wire logic                         conversion_trigger, // conversion trigger pin
  input  wire logic                         select_chain_input, // select / chain data pin
  input  wire logic [`ACR_RESULT_BITS-1:0]  conv_result,        // converter result word, mclk
  output logic                              serial_result_out,  // serial data pin level
  output logic                              serial_result_oe_n, // low while pin is driven
  output logic                              converter_power,    // high while converter runs
  output logic                              conv_busy           // high during conversion
);
  import acr_pkg::*;

  localparam int RB = `ACR_RESULT_BITS;
  localparam int CW = $clog2(CONV_CYCLES + 1);

  // core-domain state; trigger and select pass a two-stage synchroniser
  typedef struct packed {
    logic [2:0]    trg_sync;   // [0],[1] synchroniser, [2] previous value for edges
    logic [1:0]    sel_sync;
    logic [1:0]    sck_sync;
    acr_phase_t    phase;
    logic [CW-1:0] cnt;
    acr_mode_t     mode;
    logic [RB-1:0] result;
    logic          done_tgl;   // toggles once per completed conversion
    logic          start_tgl;  // toggles once per trigger rise
  } acr_core_t;

  acr_core_t c_q, c_d;

  // the first synchroniser stage feeds only the second stage
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rise

  // conversion sequencer on mclk
  always_comb
  begin
    c_d = c_q;
    c_d.trg_sync = {c_q.trg_sync[1], c_q.trg_sync[0], conversion_trigger};
    c_d.sel_sync = {c_q.sel_sync[0], select_chain_input};
    c_d.sck_sync = {c_q.sck_sync[0], shift_clk};
    // a new trigger edge restarts the sequencer whatever phase it is in
    if (rise(c_q.trg_sync[1], c_q.trg_sync[2]))
    begin
      // mode caught at the edge, select high chooses select mode
      if (c_q.sel_sync[1])
        c_d.mode = ACR_MODE_SEL;
      else if (c_q.sck_sync[1])
        c_d.mode = ACR_MODE_CHAIN_BUSY;
      else
        c_d.mode = ACR_MODE_CHAIN;
      c_d.phase     = ACR_PH_CONV;
      c_d.cnt       = '0;
      c_d.start_tgl = ~c_q.start_tgl;
    end
    else
    begin
      unique case (c_q.phase)
        ACR_PH_ACQ: ;
        ACR_PH_CONV:
        begin
          // fixed internal timing, trigger level is ignored
          if (c_q.cnt == CW'(CONV_CYCLES - 1))
          begin
            c_d.phase  = ACR_PH_DONE;
            c_d.result = conv_result;
            // select-mode busy: select or trigger low at the end
            if (c_q.mode == ACR_MODE_SEL && (!c_q.sel_sync[1] || !c_q.trg_sync[1]))
              c_d.mode = ACR_MODE_SEL_BUSY;
            c_d.done_tgl = ~c_q.done_tgl;
          end
          else
            c_d.cnt = c_q.cnt + CW'(1);
        end
        // result captured; converter powers down until next trigger
        ACR_PH_DONE: c_d.phase = ACR_PH_ACQ;
      endcase
    end
    if (srst)
    begin
      c_d       = '0;
      c_d.phase = ACR_PH_ACQ;
      c_d.mode  = ACR_MODE_SEL;
      c_d.result = `ACR_RESULT_RESET;
    end
  end

  always_ff @(posedge mclk)
  begin
    c_q <= c_d;
  end

  assign converter_power = (c_q.phase == ACR_PH_CONV);
  assign conv_busy       = (c_q.phase == ACR_PH_CONV);

  // link domain: result and mode are stable while the done toggle is seen,
  // so they cross as a word handed over by the toggle  (handshake-free hold)
  typedef struct packed {
    logic [2:0]    done_sync;  // [0],[1] synchroniser, [2] previous
    logic [2:0]    start_sync;
    logic [RB:0]   shreg;      // one extra bit carries the busy start bit
    logic [5:0]    falls;      // falling edges since completion
    logic          ready;      // data phase active
    acr_mode_t     mode;
  } acr_link_t;

  acr_link_t l_q, l_d;

  // reset reaches the link domain through two flops
  logic [1:0] srst_link_sync;
  logic       srst_link;
  always_ff @(negedge shift_clk)
  begin
    srst_link_sync <= {srst_link_sync[0], srst};
  end
  assign srst_link = srst_link_sync[1];

  // shift register advances on the shift-clock falling edge
  always_comb
  begin
    l_d = l_q;
    l_d.done_sync  = {l_q.done_sync[1], l_q.done_sync[0], c_q.done_tgl};
    l_d.start_sync = {l_q.start_sync[1], l_q.start_sync[0], c_q.start_tgl};
    if (l_q.start_sync[2] != l_q.start_sync[1])
      l_d.ready = 1'b0;
    if (l_q.done_sync[2] != l_q.done_sync[1])
    begin
      l_d.mode  = c_q.mode;
      l_d.ready = 1'b1;
      l_d.falls = '0;
      // busy modes put a leading one ahead of the msb
      if (c_q.mode == ACR_MODE_SEL_BUSY || c_q.mode == ACR_MODE_CHAIN_BUSY)
        l_d.shreg = {1'b1, c_q.result};
      else
        l_d.shreg = {c_q.result, 1'b0};
    end
    else if (l_q.ready)
    begin
      // chain modes fill from the upstream converter
      l_d.shreg = {l_q.shreg[RB-1:0],
                   (l_q.mode == ACR_MODE_CHAIN || l_q.mode == ACR_MODE_CHAIN_BUSY)
                   ? select_chain_input : 1'b0};
      if (l_q.falls != 6'h3F)
        l_d.falls = l_q.falls + 6'h01;
    end
    if (srst_link)
      l_d = '0;
  end

  always_ff @(negedge shift_clk)
  begin
    l_q <= l_d;
  end

  // pin drive: level choices per mode
  logic is_chain;
  logic sel_end;
  assign is_chain = (l_q.mode == ACR_MODE_CHAIN) || (l_q.mode == ACR_MODE_CHAIN_BUSY);
  // plain select ends at 18th fall, busy select at 19th
  assign sel_end  = (l_q.mode == ACR_MODE_SEL_BUSY) ? (l_q.falls >= 6'd19)
                                                    : (l_q.falls >= 6'd18);

  always_comb
  begin
    serial_result_out  = 1'b0;
    serial_result_oe_n = 1'b1;
    // idle low wins over any stale readout left in the link domain
    if (!c_q.sel_sync[1] && !c_q.trg_sync[1])
      serial_result_oe_n = 1'b0;
    // released while converting; the link ready flag lags the trigger edge
    else if (c_q.phase == ACR_PH_CONV)
      serial_result_oe_n = 1'b1;
    else if (l_q.ready && is_chain)
    begin
      serial_result_out  = l_q.shreg[RB];
      serial_result_oe_n = 1'b0;
    end
    else if (l_q.ready && !sel_end && (!c_q.sel_sync[1] || l_q.mode == ACR_MODE_SEL_BUSY))
    begin
      // select rising returns the pin to high impedance
      if (!(l_q.mode == ACR_MODE_SEL_BUSY && c_q.sel_sync[1] && l_q.falls != 6'd0))
      begin
        serial_result_out  = l_q.shreg[RB];
        serial_result_oe_n = 1'b0;
      end
    end
  end

endmodule : acr_readout
`default_nettype wire

//--- tb/acr_host_clk.sv
`timescale 1ns/1ps
`default_nettype none
module acr_host_clk (
  input  wire logic run,       // frame in progress
  input  wire logic idle_hi,   // level between frames
  output var  logic shift_clk  // 30 ns link clock
);
  // stands at its idle level between frames so no stray fall shifts data
  initial
  begin
    shift_clk = 1'b0;
    #3.7;
    forever #15 shift_clk = run ? ~shift_clk : idle_hi;
  end
endmodule : acr_host_clk
`default_nettype wire

//--- tb/acr_readout_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acr_readout_sva #(parameter int CONV_CYCLES = 62) (
  input wire logic mclk,               // clock
  input wire logic srst,               // reset
  input wire logic conversion_trigger, // trigger
  input wire logic select_chain_input, // select
  input wire logic serial_result_out,  // pin
  input wire logic serial_result_oe_n, // low drives
  input wire logic converter_power,    // running
  input wire logic conv_busy           // converting
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic sel_q;
  int   len_q;
  // mode from the raw pins, ahead of the synchroniser; busy length judges timing
  always_ff @(posedge mclk)
  begin
    if ($rose(conversion_trigger))
      sel_q <= select_chain_input;
    len_q <= conv_busy ? len_q + 1 : 0;
  end
  a_idle_low: assert property ((!conversion_trigger && !select_chain_input)[*6] |->
    !serial_result_oe_n && !serial_result_out) else $error("idle pin not low");
  a_power_busy: assert property (conv_busy == converter_power)
    else $error("power differs from busy");
  a_conv_len: assert property ($fell(conv_busy) |->
    len_q >= CONV_CYCLES - 1 && len_q <= CONV_CYCLES + 1) else $error("bad conversion time");
  a_trig_start: assert property ($rose(conversion_trigger) |-> ##[1:5] conv_busy)
    else $error("no conversion");
  a_sel_hiz: assert property ($rose(conversion_trigger) && select_chain_input |->
    ##[1:5] serial_result_oe_n) else $error("pin not released");
  a_conv_hiz: assert property (sel_q && conv_busy && $past(conv_busy, 3) |->
    serial_result_oe_n) else $error("pin driven in conversion");
  a_busy_drive: assert property (sel_q && !select_chain_input && $fell(conv_busy) |->
    ##[1:24] !serial_result_oe_n) else $error("no busy edge");
  a_sel_release: assert property (sel_q && conversion_trigger && !conv_busy &&
    $rose(select_chain_input) |-> ##[1:6] serial_result_oe_n) else $error("select no release");
endmodule : acr_readout_sva
bind acr_readout acr_readout_sva #(.CONV_CYCLES(CONV_CYCLES)) acr_readout_sva_inst (.*);
`default_nettype wire

//--- tb/acr_readout_test.sv
`timescale 1ns/1ps
`default_nettype none
module acr_readout_test;
  logic        mclk = 1'b0, srst = 1'b1, trig = 1'b0, sel = 1'b0, run = 1'b1, idle_hi = 1'b0;
  logic [17:0] res = 18'h00000;
  logic        shift_clk, out, oe_n, pwr, busy;
  logic [18:0] exp_q[$], acc;
  int          len_q[$], need, mismatches, n_checks, cyc;
  always #4 mclk = ~mclk;
  acr_host_clk acr_host_clk_inst (.run(run), .idle_hi(idle_hi), .shift_clk(shift_clk));
  // short conversion keeps each frame brief
  acr_readout #(.CONV_CYCLES(20)) acr_readout_inst (.mclk(mclk), .srst(srst),
    .shift_clk(shift_clk), .conversion_trigger(trig), .select_chain_input(sel),
    .conv_result(res), .serial_result_out(out), .serial_result_oe_n(oe_n),
    .converter_power(pwr), .conv_busy(busy));
  task chk(input string what, input logic [18:0] seen, input logic [18:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  // host samples mid-bit on the rise, where hold time is no concern
  // the first 1 opens a word
  always @(posedge shift_clk)
    if (trig && oe_n === 1'b0 && (need > 0 || (exp_q.size() > 0 && out === 1'b1)))
    begin
      acc = (need > 0) ? {acc[17:0], out} : 19'h00001;
      need = (need > 0) ? need - 1 : len_q.pop_front() - 1;
      if (need == 0)
        chk("word", acc, exp_q.pop_front());
    end
  // one conversion and readout; s picks select mode, ih the idle shift level
  task frame(input logic s, input logic ih);
    res <= 18'h20000 | 18'($urandom);
    sel <= s;
    idle_hi <= ih;
    repeat (4) @(posedge mclk);
    trig <= 1'b1;
    repeat (4) @(posedge mclk);
    sel <= 1'b0;
    run <= 1'b1;
    exp_q.push_back({s | ih, res});
    len_q.push_back((s | ih) ? 19 : 18);
    repeat (120) @(posedge mclk);
    run <= 1'b0;
    sel <= s;
    repeat (8) @(posedge mclk);
    trig <= 1'b0;
    sel <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : frame
  initial
  begin
    void'($urandom(32'hC8E6D449));
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    run <= 1'b0;
    repeat (2)
      for (int m = 0; m < 3; m++)
        frame(m == 2, m == 1);
    chk("pending", 19'(exp_q.size()), 19'h00000);
    test_done();
  end
  // cut a hang short
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      test_done();
    end
  end
endmodule : acr_readout_test
`default_nettype wire
